// file: core/mscr_pkg.sv
package mscr_pkg;

   // ****************************************************************
   // Register map and field layout
   // ****************************************************************
   localparam int          ADDR_W        = 8;
   localparam int          DATA_W        = 32;
   localparam logic [7:0]  OFF_CFG_ONE   = 8'h82;
   localparam logic [7:0]  OFF_CFG_TWO   = 8'h84;
   localparam logic [7:0]  OFF_SELECT    = 8'h88;
   localparam logic [31:0] RESET_CFG     = 32'h0000_0000;
   localparam logic [31:0] RESET_SELECT  = 32'h0000_0000;

   localparam int PARITY_BIT   = 31;
   localparam int PDCUR_LSB    = 8;
   localparam int PDADV_LSB    = 6;
   localparam int PDCNT_LSB    = 4;
   localparam int FCFREQ_LSB   = 0;
   localparam int OLDUTY_LSB   = 28;
   localparam int OLCUR_LSB    = 23;
   localparam int OLACC_LSB    = 18;
   localparam int FCSEL_BIT    = 6;
   localparam int METHOD_LSB   = 0;
   localparam int BIDIR_BIT    = 2;

   // Roll-over limits and reserved codes.
   localparam logic [4:0] CUR_ROLL_UNI = 5'h1B;
   localparam logic [4:0] CUR_ROLL_BI  = 5'h0F;
   localparam logic [4:0] OL_CUR_MAX   = 5'h1A;
   localparam logic [3:0] FC_RESERVED  = 4'hA;
   localparam logic [4:0] ACC_NOLIMIT  = 5'h1F;
   localparam logic [15:0] ACC_UNLIMITED = 16'h7FFF;
   // Offset in millivolts for the unidirectional amplifier.
   localparam logic [11:0] OFFSET_UNI_MV = 12'h04B;
   localparam logic [11:0] STEP_MV       = 12'h064;

   typedef enum logic [1:0] {
      MSCR_ALIGN   = 2'b00,
      MSCR_DALIGN  = 2'b01,
      MSCR_PDETECT = 2'b10,
      MSCR_SLOWFC  = 2'b11
   } mscr_method_t;

endpackage

// file: core/mscr_regs.sv
// Design decision made here: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module mscr_regs
   import mscr_pkg::*;
(
   input  wire logic                      clk,
   input  wire logic                      rst,
   input  wire logic [mscr_pkg::ADDR_W-1:0] addr,
   input  wire logic [mscr_pkg::DATA_W-1:0] wrData,
   input  wire logic                      wrStrobe,
   input  wire logic                      rdStrobe,
   output logic      [mscr_pkg::DATA_W-1:0] rdData,
   output logic                           pdEnable,
   output logic                           slowCycleEnable,
   output logic      [11:0]               pdTripMv,
   output logic      [6:0]                pdAdvanceDeg,
   output logic      [2:0]                pdPasses,
   output logic      [15:0]               firstCycleCentiHz,
   output logic                           firstCycleReserved,
   output logic      [6:0]                openLoopDutyPct,
   output logic      [11:0]               openLoopTripMv,
   output logic                           openLoopCurNa,
   output logic      [15:0]               openLoopAccelMilli
);
   import mscr_pkg::*;

   // ****************************************************************
   // Decode functions
   // ****************************************************************

   // Threshold code to millivolts, shared by both current limits.
   function automatic logic [11:0] codeToMv(input logic [4:0] code, input logic bidir);
      logic [4:0]  eff;
      logic [11:0] raw;
      eff = code;
      if (bidir && code > CUR_ROLL_BI) begin
         eff = code & CUR_ROLL_BI;
      end else if (!bidir && code > CUR_ROLL_UNI) begin
         eff = 5'h00;
      end
      raw = 12'(eff) * STEP_MV;
      if (!bidir) begin
         codeToMv = (raw > OFFSET_UNI_MV) ? raw - OFFSET_UNI_MV : 12'h000;
      end else begin
         codeToMv = raw;
      end
   endfunction

   // ****************************************************************
   // Register storage
   // ****************************************************************
   logic [DATA_W-1:0] cfgOne;
   logic [DATA_W-1:0] cfgTwo;
   logic [DATA_W-1:0] selectReg;

   // Register one, including its parity bit, is plain storage.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cfgOne <= RESET_CFG;
      end else if (wrStrobe && addr == OFF_CFG_ONE) begin
         cfgOne <= wrData;
      end
   end

   // Register two at its own offset.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cfgTwo <= RESET_CFG;
      end else if (wrStrobe && addr == OFF_CFG_TWO) begin
         cfgTwo <= wrData;
      end
   end

   // Method, first-cycle selector and amplifier direction share one register.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         selectReg <= RESET_SELECT;
      end else if (wrStrobe && addr == OFF_SELECT) begin
         selectReg <= {25'h0000000, wrData[FCSEL_BIT:0]};
      end
   end

   // Read data stands only in the cycle after the strobe; unmapped reads give zero.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdData <= 32'h0000_0000;
      end else if (rdStrobe) begin
         case (addr)
            OFF_CFG_ONE: rdData <= cfgOne;
            OFF_CFG_TWO: rdData <= cfgTwo;
            OFF_SELECT:  rdData <= selectReg;
            default:     rdData <= 32'h0000_0000;
         endcase
      end else begin
         rdData <= 32'h0000_0000;
      end
   end

   // ****************************************************************
   // Field decode
   // ****************************************************************
   mscr_method_t method;
   logic         bidir;
   logic         fcZero;
   logic [15:0]  fcTable;
   logic [6:0]   dutyTable;
   logic [15:0]  accTable;

   assign method = mscr_method_t'(selectReg[METHOD_LSB +: 2]);
   assign bidir  = selectReg[BIDIR_BIT];
   assign fcZero = selectReg[FCSEL_BIT];

   // First-cycle frequency in hundredths of a hertz; code Ah has no value.
   always_comb begin
      case (cfgOne[FCFREQ_LSB +: 4])
         4'h0: fcTable = 16'h0005;
         4'h1: fcTable = 16'h000A;
         4'h2: fcTable = 16'h0019;
         4'h3: fcTable = 16'h0032;
         4'h4: fcTable = 16'h0064;
         4'h5: fcTable = 16'h00C8;
         4'h6: fcTable = 16'h012C;
         4'h7: fcTable = 16'h01F4;
         4'h8: fcTable = 16'h03E8;
         4'h9: fcTable = 16'h05DC;
         4'hB: fcTable = 16'h09C4;
         4'hC: fcTable = 16'h1388;
         4'hD: fcTable = 16'h2710;
         4'hE: fcTable = 16'h3A98;
         4'hF: fcTable = 16'h4E20;
         default: fcTable = 16'h0000;
      endcase
   end

   // Open-loop duty limit in percent.
   always_comb begin
      case (cfgTwo[OLDUTY_LSB +: 3])
         3'h0: dutyTable = 7'h0A;
         3'h1: dutyTable = 7'h0F;
         3'h2: dutyTable = 7'h14;
         3'h3: dutyTable = 7'h19;
         3'h4: dutyTable = 7'h1E;
         3'h5: dutyTable = 7'h28;
         3'h6: dutyTable = 7'h32;
         default: dutyTable = 7'h64;
      endcase
   end

   // Acceleration in thousandths of Hz/s, saturated at the no-limit value.
   always_comb begin
      case (cfgTwo[OLACC_LSB +: 5])
         5'h00: accTable = 16'h0005;
         5'h01: accTable = 16'h000A;
         5'h02: accTable = 16'h0019;
         5'h03: accTable = 16'h0032;
         5'h04: accTable = 16'h0064;
         5'h05: accTable = 16'h00FA;
         5'h06: accTable = 16'h01F4;
         5'h07: accTable = 16'h03E8;
         5'h08: accTable = 16'h09C4;
         5'h09: accTable = 16'h1388;
         5'h0A: accTable = 16'h1D4C;
         5'h0B: accTable = 16'h2710;
         5'h0C: accTable = 16'h30D4;
         5'h0D: accTable = 16'h3A98;
         5'h0E: accTable = 16'h4E20;
         5'h0F: accTable = 16'h7530;
         default: accTable = ACC_UNLIMITED; // Larger rates exceed the output width.
      endcase
   end

   // Outputs are registered so the consuming algorithm sees glitch-free settings.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pdEnable           <= 1'b0;
         slowCycleEnable    <= 1'b0;
         pdTripMv           <= 12'h000;
         pdAdvanceDeg       <= 7'h00;
         pdPasses           <= 3'h1;
         firstCycleCentiHz  <= 16'h0000;
         firstCycleReserved <= 1'b0;
         openLoopDutyPct    <= 7'h0A;
         openLoopTripMv     <= 12'h000;
         openLoopCurNa      <= 1'b0;
         openLoopAccelMilli <= 16'h0005;
      end else begin
         pdEnable           <= (method == MSCR_PDETECT);
         slowCycleEnable    <= (method == MSCR_SLOWFC);
         pdTripMv           <= codeToMv(cfgOne[PDCUR_LSB +: 5], bidir);
         pdAdvanceDeg       <= 7'(cfgOne[PDADV_LSB +: 2]) * 7'h1E;
         pdPasses           <= 3'(cfgOne[PDCNT_LSB +: 2]) + 3'h1;
         firstCycleCentiHz  <= fcZero ? 16'h0000 : fcTable;
         firstCycleReserved <= (cfgOne[FCFREQ_LSB +: 4] == FC_RESERVED);
         openLoopDutyPct    <= dutyTable;
         openLoopTripMv     <= codeToMv(cfgTwo[OLCUR_LSB +: 5], bidir);
         openLoopCurNa      <= (cfgTwo[OLCUR_LSB +: 5] > OL_CUR_MAX);
         openLoopAccelMilli <= accTable;
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   a_read_one: assert property (@(posedge clk) disable iff (rst)
      rdStrobe && addr == OFF_CFG_ONE |=> rdData == $past(cfgOne))
      else $error("Register one read mismatch.");
   a_write_two: assert property (@(posedge clk) disable iff (rst)
      wrStrobe && addr == OFF_CFG_TWO && !rdStrobe |=> cfgTwo == $past(wrData))
      else $error("Register two write lost.");
   a_parity_keep: assert property (@(posedge clk) disable iff (rst)
      wrStrobe && addr == OFF_CFG_ONE |=> cfgOne[PARITY_BIT] == $past(wrData[PARITY_BIT]))
      else $error("Parity bit not stored.");
   a_pass_count: assert property (@(posedge clk) disable iff (rst)
      ##1 pdPasses == 3'($past(cfgOne[PDCNT_LSB +: 2])) + 3'h1)
      else $error("Pass count wrong.");
   a_advance_max: assert property (@(posedge clk) disable iff (rst)
      cfgOne[PDADV_LSB +: 2] == 2'h3 && $stable(cfgOne) |=> pdAdvanceDeg == 7'h5A)
      else $error("Advance angle wrong.");
   a_fc_zero: assert property (@(posedge clk) disable iff (rst)
      fcZero |=> firstCycleCentiHz == 16'h0000)
      else $error("First cycle not zero.");
   a_acc_nolimit: assert property (@(posedge clk) disable iff (rst)
      cfgTwo[OLACC_LSB +: 5] == ACC_NOLIMIT |=> openLoopAccelMilli == ACC_UNLIMITED)
      else $error("No-limit acceleration wrong.");
   a_method_pd: assert property (@(posedge clk) disable iff (rst)
      method == MSCR_PDETECT |=> pdEnable && !slowCycleEnable)
      else $error("Detection not enabled.");
   a_duty_full: assert property (@(posedge clk) disable iff (rst)
      cfgTwo[OLDUTY_LSB +: 3] == 3'h7 |=> openLoopDutyPct == 7'h64)
      else $error("Full duty wrong.");
   a_ol_na: assert property (@(posedge clk) disable iff (rst)
      cfgTwo[OLCUR_LSB +: 5] == 5'h1B |=> openLoopCurNa)
      else $error("Not-applicable flag missing.");
   a_reserved_fc: assert property (@(posedge clk) disable iff (rst)
      cfgOne[FCFREQ_LSB +: 4] == FC_RESERVED |=> firstCycleReserved)
      else $error("Reserved code not flagged.");


   // ****************************************************************
   // Register access checks
   // ****************************************************************

   // Both configuration words read back and store whole written words.
   a_read_two: assert property (@(posedge clk) disable iff (rst)
      rdStrobe && addr == OFF_CFG_TWO |=> rdData == $past(cfgTwo))
      else $error("Register two read mismatch.");
   a_write_one: assert property (@(posedge clk) disable iff (rst)
      wrStrobe && addr == OFF_CFG_ONE |=> cfgOne == $past(wrData))
      else $error("Register one write lost.");
   a_parity_two: assert property (@(posedge clk) disable iff (rst)
      wrStrobe && addr == OFF_CFG_TWO |=> cfgTwo[PARITY_BIT] == $past(wrData[PARITY_BIT]))
      else $error("Register two parity bit not stored.");

   // A word must not move unless its own offset is written.
   a_hold_one: assert property (@(posedge clk) disable iff (rst)
      !(wrStrobe && addr == OFF_CFG_ONE) |=> $stable(cfgOne))
      else $error("Register one changed without a write.");
   a_hold_two: assert property (@(posedge clk) disable iff (rst)
      !(wrStrobe && addr == OFF_CFG_TWO) |=> $stable(cfgTwo))
      else $error("Register two changed without a write.");

   // Read data is zero outside the cycle after a mapped read.
   a_read_idle: assert property (@(posedge clk) disable iff (rst)
      !rdStrobe |=> rdData == 32'h0000_0000)
      else $error("Read data not idle.");
   a_read_unmapped: assert property (@(posedge clk) disable iff (rst)
      rdStrobe && addr != OFF_CFG_ONE && addr != OFF_CFG_TWO && addr != OFF_SELECT
      |=> rdData == 32'h0000_0000)
      else $error("Unmapped read not zero.");
   a_select_upper: assert property (@(posedge clk) disable iff (rst)
      selectReg[DATA_W-1:FCSEL_BIT+1] == 25'h0000000)
      else $error("Select word upper bits not zero.");

   // ****************************************************************
   // Decode checks
   // ****************************************************************

   // Method decode: only one start-up path may be enabled at a time.
   a_method_slow: assert property (@(posedge clk) disable iff (rst)
      method == MSCR_SLOWFC |=> slowCycleEnable && !pdEnable)
      else $error("Slow first cycle not enabled.");
   a_method_align: assert property (@(posedge clk) disable iff (rst)
      method == MSCR_ALIGN |=> !pdEnable && !slowCycleEnable)
      else $error("Align method enabled a start-up path.");

   // Current thresholds at the ends of their ranges.
   a_pd_zero: assert property (@(posedge clk) disable iff (rst)
      cfgOne[PDCUR_LSB +: 5] == 5'h00 |=> pdTripMv == 12'h000)
      else $error("Zero detect threshold wrong.");
   a_uni_top: assert property (@(posedge clk) disable iff (rst)
      !bidir && cfgOne[PDCUR_LSB +: 5] == CUR_ROLL_UNI |=> pdTripMv == 12'hA41)
      else $error("Unidirectional top threshold wrong.");
   a_bidir_wrap: assert property (@(posedge clk) disable iff (rst)
      bidir && cfgOne[PDCUR_LSB +: 5] == 5'h1F |=> pdTripMv == 12'h5DC)
      else $error("Bidirectional roll-over wrong.");
   a_ol_zero: assert property (@(posedge clk) disable iff (rst)
      cfgTwo[OLCUR_LSB +: 5] == 5'h00 |=> openLoopTripMv == 12'h000)
      else $error("Zero open-loop threshold wrong.");
   a_ol_valid: assert property (@(posedge clk) disable iff (rst)
      cfgTwo[OLCUR_LSB +: 5] <= OL_CUR_MAX |=> !openLoopCurNa)
      else $error("Valid open-loop code flagged.");

   // Angle and pass count decode.
   a_advance_zero: assert property (@(posedge clk) disable iff (rst)
      cfgOne[PDADV_LSB +: 2] == 2'h0 |=> pdAdvanceDeg == 7'h00)
      else $error("Zero advance wrong.");
   a_advance_one: assert property (@(posedge clk) disable iff (rst)
      cfgOne[PDADV_LSB +: 2] == 2'h1 |=> pdAdvanceDeg == 7'h1E)
      else $error("Single-step advance wrong.");
   a_pass_four: assert property (@(posedge clk) disable iff (rst)
      cfgOne[PDCNT_LSB +: 2] == 2'h3 |=> pdPasses == 3'h4)
      else $error("Four-pass count wrong.");

   // Frequency, duty and acceleration tables at chosen codes.
   a_fc_base: assert property (@(posedge clk) disable iff (rst)
      !fcZero && cfgOne[FCFREQ_LSB +: 4] == 4'h4 |=> firstCycleCentiHz == 16'h0064)
      else $error("One hertz first cycle wrong.");
   a_fc_top: assert property (@(posedge clk) disable iff (rst)
      !fcZero && cfgOne[FCFREQ_LSB +: 4] == 4'hF |=> firstCycleCentiHz == 16'h4E20)
      else $error("Top first-cycle frequency wrong.");
   a_fc_reserved_zero: assert property (@(posedge clk) disable iff (rst)
      cfgOne[FCFREQ_LSB +: 4] == FC_RESERVED |=> firstCycleCentiHz == 16'h0000)
      else $error("Reserved code gave a frequency.");
   a_duty_low: assert property (@(posedge clk) disable iff (rst)
      cfgTwo[OLDUTY_LSB +: 3] == 3'h0 |=> openLoopDutyPct == 7'h0A)
      else $error("Lowest duty wrong.");
   a_duty_half: assert property (@(posedge clk) disable iff (rst)
      cfgTwo[OLDUTY_LSB +: 3] == 3'h6 |=> openLoopDutyPct == 7'h32)
      else $error("Half duty wrong.");
   a_acc_slowest: assert property (@(posedge clk) disable iff (rst)
      cfgTwo[OLACC_LSB +: 5] == 5'h00 |=> openLoopAccelMilli == 16'h0005)
      else $error("Slowest acceleration wrong.");

   c_pd_four:   cover property (@(posedge clk) pdEnable && pdPasses == 3'h4);
   c_write_one: cover property (@(posedge clk) wrStrobe && addr == OFF_CFG_ONE);
   c_read_two:  cover property (@(posedge clk) rdStrobe && addr == OFF_CFG_TWO);
   c_slow_fc:   cover property (@(posedge clk) slowCycleEnable && !fcZero);
   c_bidir:     cover property (@(posedge clk) bidir && pdTripMv != 12'h000);

endmodule
`default_nettype wire

// file: verif/motor_startup_config_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none
module motor_startup_config_regs_tb;
   import mscr_pkg::*;

   // ****************************************************************
   // Stimulus tables
   // ****************************************************************
   typedef struct {int par; int pdCur; int adv; int cnt; int olCur; int sel;
                   int pdMv; int advDeg; int passes; int olMv;} mscr_row_t;
   // Rows mix amplifier modes, methods and the current-code roll-over edges.
   mscr_row_t rows[7] = '{
      '{0, 5'h00, 0, 0, 5'h00, 8'h02,    0,  0, 1,    0},
      '{1, 5'h01, 1, 1, 5'h01, 8'h03,   25, 30, 2,   25},
      '{0, 5'h1B, 2, 2, 5'h1A, 8'h01, 2625, 60, 3, 2525},
      '{1, 5'h1C, 3, 3, 5'h0A, 8'h00,    0, 90, 4,  925},
      '{0, 5'h0F, 0, 0, 5'h0F, 8'h06, 1500,  0, 1, 1500},
      '{1, 5'h1F, 1, 2, 5'h11, 8'h07, 1500, 30, 3,  100},
      '{0, 5'h10, 2, 1, 5'h03, 8'h43, 1525, 60, 2,  225}};
   int fcTab[16] = '{5, 10, 25, 50, 100, 200, 300, 500, 1000, 1500, 0, 2500, 5000,
                     10000, 15000, 20000};
   int accTab[32] = '{5, 10, 25, 50, 100, 250, 500, 1000, 2500, 5000, 7500, 10000,
                      12500, 15000, 20000, 30000, 32767, 32767, 32767, 32767, 32767,
                      32767, 32767, 32767, 32767, 32767, 32767, 32767, 32767, 32767,
                      32767, 32767};
   int dutyTab[8] = '{10, 15, 20, 25, 30, 40, 50, 100};

   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wrData = 32'h0000_0000;
   logic        wrStrobe = 1'b0;
   logic        rdStrobe = 1'b0;
   logic [31:0] rdData;
   logic        pdEnable, slowCycleEnable, firstCycleReserved, openLoopCurNa;
   logic [11:0] pdTripMv, openLoopTripMv;
   logic [6:0]  pdAdvanceDeg, openLoopDutyPct;
   logic [2:0]  pdPasses;
   logic [15:0] firstCycleCentiHz, openLoopAccelMilli;
   logic [31:0] w1, w2;
   int          nFail = 0;
   int          checked = 0;

   mscr_regs dut (.clk(clk), .rst(rst), .addr(addr), .wrData(wrData),
      .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData), .pdEnable(pdEnable),
      .slowCycleEnable(slowCycleEnable), .pdTripMv(pdTripMv), .pdAdvanceDeg(pdAdvanceDeg),
      .pdPasses(pdPasses), .firstCycleCentiHz(firstCycleCentiHz),
      .firstCycleReserved(firstCycleReserved), .openLoopDutyPct(openLoopDutyPct),
      .openLoopTripMv(openLoopTripMv), .openLoopCurNa(openLoopCurNa),
      .openLoopAccelMilli(openLoopAccelMilli));

   // Free-running 25 MHz clock.
   always #20 clk = ~clk;

   // ****************************************************************
   // Bus and compare tasks
   // ****************************************************************
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         nFail++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wrStrobe <= 1'b1;
      addr     <= a;
      wrData   <= d;
      @(posedge clk);
      wrStrobe <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe, so sample there.
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      rdStrobe <= 1'b1;
      addr     <= a;
      @(posedge clk);
      rdStrobe <= 1'b0;
      @(negedge clk);
      chk("rdData", exp, rdData);
   endtask

   // Decoded outputs trail a write by one cycle; settle waits two.
   task automatic settle;
      repeat (2) @(posedge clk);
      @(negedge clk);
   endtask

   task automatic test_done;
      if (nFail == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // A hang would otherwise stall the run with no verdict.
   initial begin
      repeat (5000) @(posedge clk);
      nFail++;
      test_done();
   end

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      // Row cases: current thresholds, angle, passes and method flags.
      foreach (rows[i]) begin
         w1 = {rows[i].par[0], 18'h0, rows[i].pdCur[4:0], rows[i].adv[1:0],
               rows[i].cnt[1:0], 4'h4};
         w2 = {rows[i].par[0], 3'h0, rows[i].olCur[4:0], 23'h0};
         wr(OFF_CFG_ONE, w1);
         wr(OFF_CFG_TWO, w2);
         wr(OFF_SELECT, {24'h0, rows[i].sel[7:0]});
         settle();
         chk("pdTripMv", rows[i].pdMv, pdTripMv);
         chk("pdAdvanceDeg", rows[i].advDeg, pdAdvanceDeg);
         chk("pdPasses", rows[i].passes, pdPasses);
         chk("openLoopTripMv", rows[i].olMv, openLoopTripMv);
         chk("openLoopCurNa", rows[i].olCur > 'h1A, openLoopCurNa);
         chk("pdEnable", rows[i].sel[1:0] == 2, pdEnable);
         chk("slowCycleEnable", rows[i].sel[1:0] == 3, slowCycleEnable);
         chk("firstCycleCentiHz", rows[i].sel[6] ? 0 : 100, firstCycleCentiHz);
         rd(OFF_CFG_ONE, w1);
         rd(OFF_CFG_TWO, w2);
      end
      // Sweep every code of the frequency, duty and acceleration tables.
      wr(OFF_SELECT, 32'h0000_0000);
      for (int i = 0; i < 32; i++) begin
         wr(OFF_CFG_ONE, {28'h0, i[3:0]});
         wr(OFF_CFG_TWO, {1'b0, i[2:0], 5'h1B, i[4:0], 18'h0});
         settle();
         chk("firstCycleCentiHz", fcTab[i[3:0]], firstCycleCentiHz);
         chk("firstCycleReserved", i[3:0] == 4'hA, firstCycleReserved);
         chk("openLoopDutyPct", dutyTab[i[2:0]], openLoopDutyPct);
         chk("openLoopAccelMilli", accTab[i], openLoopAccelMilli);
         chk("openLoopCurNa", 1'b1, openLoopCurNa);
      end
      // Write followed at once by a read of the same word, then an idle cycle.
      @(posedge clk);
      wrStrobe <= 1'b1;
      addr     <= OFF_CFG_TWO;
      wrData   <= 32'hF5FC_0000;
      @(posedge clk);
      wrStrobe <= 1'b0;
      rdStrobe <= 1'b1;
      @(posedge clk);
      rdStrobe <= 1'b0;
      @(negedge clk);
      chk("rdData", 32'hF5FC_0000, rdData);
      @(negedge clk);
      chk("rdData idle", 32'h0000_0000, rdData);
      // Unmapped place and the upper bits of the select word.
      wr(8'h86, 32'hFFFF_FFFF);
      rd(8'h86, 32'h0000_0000);
      rd(OFF_CFG_TWO, 32'hF5FC_0000);
      wr(OFF_SELECT, 32'hFFFF_FFFF);
      rd(OFF_SELECT, 32'h0000_007F);
      settle();
      chk("slowCycleEnable", 1'b1, slowCycleEnable);
      chk("firstCycleCentiHz", 32'h0, firstCycleCentiHz);
      // Reset in mid-run clears every word and returns pass count, duty, acceleration and slow-cycle enable to their reset values.
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rd(OFF_CFG_ONE, 32'h0000_0000);
      rd(OFF_CFG_TWO, 32'h0000_0000);
      rd(OFF_SELECT, 32'h0000_0000);
      chk("pdPasses", 1, pdPasses);
      chk("openLoopDutyPct", 10, openLoopDutyPct);
      chk("openLoopAccelMilli", 5, openLoopAccelMilli);
      chk("slowCycleEnable", 1'b0, slowCycleEnable);
      test_done();
   end
endmodule
`default_nettype wire
